// ---- bssp_params.svh ----
// timing and field constants for the byte-select sram bus port
// assumes inclusion from package and modules alike
`ifndef BSSP_PARAMS_SVH
`define BSSP_PARAMS_SVH
`define BSSP_ADDR_W       24
`define BSSP_DATA_W       16
`define BSSP_AREAS        8
`define BSSP_AREA_MSB     23
`define BSSP_AREA_LSB     21
`define BSSP_IDLE_CNT_W   2
`define BSSP_IDLE_RST     2'h0
`define BSSP_WAIT_CNT_W   4
`define BSSP_WAIT_SETTLE  4'h1
`endif

// ---- bssp_pkg.sv ----
// types shared by the byte-select sram bus port
// assumes bssp_params.svh on the include path
`include "bssp_params.svh"
package bssp_pkg;
    typedef enum logic [1:0] {
        BSSP_ST_IDLE,
        BSSP_ST_GAP,
        BSSP_ST_T1,
        BSSP_ST_T2
    } bssp_state_e;
    typedef logic [`BSSP_ADDR_W-1:0] bssp_addr_t;
    typedef logic [`BSSP_DATA_W-1:0] bssp_data_t;
endpackage

// ---- bssp_sync_if.sv ----
// carrier between the port core and its pin synchroniser
// assumes a single clock mclk
interface bssp_sync_if;
    logic wait_raw_n;
    logic wait_sync_n;
    modport core (input wait_sync_n);
    modport sync (input wait_raw_n, output wait_sync_n);
endinterface

// ---- bssp_sync2.sv ----
// two-flop synchroniser for the wait pin
// assumes pin is asynchronous to mclk
module bssp_sync2 (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // pin side and core side
    bssp_sync_if.sync sif
);
    logic s1_reg;
    logic s1_next;
    logic s2_reg;
    logic s2_next;
    always_comb begin
        s1_next = clk_en ? sif.wait_raw_n : s1_reg;
        s2_next = clk_en ? s1_reg : s2_reg;
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s1_reg <= 1'h1;
            s2_reg <= 1'h1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end
    assign sif.wait_sync_n = s2_reg;
endmodule // bssp_sync2

// ---- bssp_port.sv ----
// external bus port driving a byte-control sram and other areas
// assumes internal master holds its request until ack
`include "bssp_params.svh"
module bssp_port
    import bssp_pkg::*;
#(
    parameter int WAIT_MAX = 15
) (
    // clock, enable, reset
    input  wire logic                   mclk,
    input  wire logic                   clk_en,
    input  wire logic                   rst_b,
    // idle cycle control, area type and width
    input  wire logic                   idle_after_single_write_en,
    input  wire logic                   idle_count_sel_hi,
    input  wire logic                   idle_count_sel_lo,
    input  wire logic [`BSSP_AREAS-1:0] area_byte_sram,
    input  wire logic [`BSSP_AREAS-1:0] area_wide,
    // internal master
    input  wire logic                   req,
    input  wire logic                   req_write,
    input  wire logic                   req_single_dma,
    input  wire logic [1:0]             req_bytes,
    input  wire bssp_addr_t             req_addr,
    input  wire bssp_data_t             req_wdata,
    output logic                        ack,
    output bssp_data_t                  rdata,
    // external pins
    output bssp_addr_t                  addr_out,
    output logic                        address_valid_strobe_n,
    output logic [`BSSP_AREAS-1:0]      area_select_n,
    output logic                        read_strobe_n,
    output logic                        rd_wr_n,
    output logic                        upper_write_strobe_n,
    output logic                        lower_write_strobe_n,
    input  wire logic                   wait_n,
    input  wire bssp_data_t             data_in,
    output bssp_data_t                  data_out,
    output logic                        data_oe
);
    ////////////////////////////////////////////////////////////////////
    // wait pin is asynchronous; only the second flop feeds the core
    bssp_sync_if sif ();
    assign sif.wait_raw_n = wait_n;
    bssp_sync2 u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .clk_en(clk_en),
        .sif   (sif)
    );

    ////////////////////////////////////////////////////////////////////
    bssp_state_e                  st_reg;
    bssp_state_e                  st_next;
    bssp_addr_t                   addr_reg;
    bssp_addr_t                   addr_next;
    bssp_data_t                   wd_reg;
    bssp_data_t                   wd_next;
    bssp_data_t                   rd_reg;
    bssp_data_t                   rd_next;
    logic                         wr_reg;
    logic                         wr_next;
    logic [1:0]                   bytes_reg;
    logic [1:0]                   bytes_next;
    logic                         sdw_reg;
    logic                         sdw_next;
    logic                         sdma_reg;
    logic                         sdma_next;
    logic [`BSSP_IDLE_CNT_W-1:0]  gap_reg;
    logic [`BSSP_IDLE_CNT_W-1:0]  gap_next;
    logic [`BSSP_WAIT_CNT_W-1:0]  wcnt_reg;
    logic [`BSSP_WAIT_CNT_W-1:0]  wcnt_next;
    logic                         ack_next;
    logic                         ack_reg;
    logic [2:0]                   area;
    logic                         bsram;
    logic [`BSSP_IDLE_CNT_W-1:0]  idle_sel;

    assign area     = addr_reg[`BSSP_AREA_MSB:`BSSP_AREA_LSB];
    assign bsram    = area_byte_sram[area];
    assign idle_sel = {idle_count_sel_hi, idle_count_sel_lo};

    always_comb begin
        st_next    = st_reg;
        addr_next  = addr_reg;
        wd_next    = wd_reg;
        rd_next    = rd_reg;
        wr_next    = wr_reg;
        bytes_next = bytes_reg;
        sdw_next   = sdw_reg;
        sdma_next  = sdma_reg;
        gap_next   = gap_reg;
        wcnt_next  = wcnt_reg;
        // a frozen clock holds the pulse too, like every other register
        ack_next   = ack_reg;
        if (clk_en) begin
            ack_next = 1'h0;
            unique case (st_reg)
                BSSP_ST_IDLE: begin
                    if (req && !ack_reg) begin
                        addr_next  = req_addr;
                        wd_next    = req_wdata;
                        wr_next    = req_write;
                        bytes_next = req_bytes;
                        sdma_next  = req_single_dma && req_write;
                        // gap keeps the outside writer off our data
                        if (sdw_reg && idle_after_single_write_en &&
                            idle_sel != 2'h0) begin
                            gap_next = idle_sel - 2'h1;
                            st_next  = BSSP_ST_GAP;
                        end else begin
                            st_next = BSSP_ST_T1;
                        end
                    end
                end
                BSSP_ST_GAP: begin
                    if (gap_reg == 2'h0)
                        st_next = BSSP_ST_T1;
                    else
                        gap_next = gap_reg - 2'h1;
                end
                BSSP_ST_T1: begin
                    wcnt_next = 4'h0;
                    st_next   = BSSP_ST_T2;
                end
                BSSP_ST_T2: begin
                    // the pin reaches us two flops late: the first T2 cycle
                    // still shows it from before the select, so hold one
                    // settle cycle or a wait raised in T1 would be missed;
                    // costs one cycle on every access
                    if (wcnt_reg < `BSSP_WAIT_SETTLE) begin
                        wcnt_next = wcnt_reg + 4'h1;
                    // bounded so a stuck pin cannot hang the bus
                    end else if (!sif.wait_sync_n &&
                        wcnt_reg != WAIT_MAX[`BSSP_WAIT_CNT_W-1:0]) begin
                        wcnt_next = wcnt_reg + 4'h1;
                    end else begin
                        rd_next  = data_in;
                        ack_next = 1'h1;
                        sdw_next = sdma_reg;
                        st_next  = BSSP_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_reg    <= BSSP_ST_IDLE;
            addr_reg  <= 24'h000000;
            wd_reg    <= 16'h0000;
            rd_reg    <= 16'h0000;
            wr_reg    <= 1'h0;
            bytes_reg <= 2'h0;
            sdw_reg   <= 1'h0;
            sdma_reg  <= 1'h0;
            gap_reg   <= `BSSP_IDLE_RST;
            wcnt_reg  <= 4'h0;
            ack_reg   <= 1'h0;
        end else begin
            st_reg    <= st_next;
            addr_reg  <= addr_next;
            wd_reg    <= wd_next;
            rd_reg    <= rd_next;
            wr_reg    <= wr_next;
            bytes_reg <= bytes_next;
            sdw_reg   <= sdw_next;
            sdma_reg  <= sdma_next;
            gap_reg   <= gap_next;
            wcnt_reg  <= wcnt_next;
            ack_reg   <= ack_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic active;
    logic wide;
    logic strobe_t2;
    logic sel_upper_n;
    logic sel_lower_n;
    logic str_upper_n;
    logic str_lower_n;
    assign active    = (st_reg == BSSP_ST_T1) || (st_reg == BSSP_ST_T2);
    assign wide      = area_wide[area];
    assign strobe_t2 = (st_reg == BSSP_ST_T2) && wr_reg;

    assign ack      = ack_reg;
    assign rdata    = rd_reg;
    assign addr_out = addr_reg;
    assign address_valid_strobe_n = !active;
    always_comb begin
        area_select_n = '1;
        if (active)
            area_select_n[area] = 1'h0;
    end
    // byte-control: oe on read only, we level on rd/wr
    assign read_strobe_n = !(active && !wr_reg);
    assign rd_wr_n       = !(active && wr_reg && bsram) &&
                           !(wr_reg && !bsram);
    // in byte-control space strobes become byte selects for both directions
    assign sel_upper_n = !(active && wide && bytes_reg[1]);
    assign sel_lower_n = !(active && (bytes_reg[0] || !wide));
    // basic space: plain write strobes, held off T1 so data settles first
    assign str_upper_n = !(strobe_t2 && bytes_reg[1]);
    assign str_lower_n = !(strobe_t2 && bytes_reg[0]);
    assign upper_write_strobe_n = bsram ? sel_upper_n : str_upper_n;
    assign lower_write_strobe_n = bsram ? sel_lower_n : str_lower_n;
    assign data_out = wd_reg;
    assign data_oe  = active && wr_reg;
endmodule // bssp_port

// ---- bssp_port_props.sv ----
// pin assertions for the byte-select sram bus port
// assumes single clock mclk; clk_en only stretches cycles
module bssp_port_props
    import bssp_pkg::*;
(
    // clock, reset, request side
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       req,
    input wire logic       ack,
    input wire logic [7:0] area_byte_sram,
    input wire logic [7:0] area_wide,
    // external pins
    input wire bssp_addr_t addr_out,
    input wire logic       address_valid_strobe_n,
    input wire logic [7:0] area_select_n,
    input wire logic       read_strobe_n,
    input wire logic       rd_wr_n,
    input wire logic       upper_write_strobe_n,
    input wire logic       data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire       v_n = address_valid_strobe_n;
    wire [2:0] ar = addr_out[23:21];
    ////////////////////////////////////////////////////////////////////////
    one_sel_a: assert property (
        !v_n |-> $onehot(~area_select_n)) else $error("select count");
    right_sel_a: assert property (
        !v_n |-> !area_select_n[ar]) else $error("wrong area select");
    idle_sel_a: assert property (
        v_n |-> &area_select_n) else $error("select without strobe");
    read_oe_a: assert property (
        !read_strobe_n |-> !v_n && !data_oe) else $error("read enable");
    two_state_a: assert property (
        $fell(v_n) |=> !v_n) else $error("strobe too short");
    ack_bound_a: assert property (
        $rose(req) |-> ##[3:40] ack) else $error("no ack");
    upper_wide_a: assert property (
        !upper_write_strobe_n && area_byte_sram[ar] |-> area_wide[ar])
        else $error("upper select on narrow area");
    byte_we_a: assert property (
        data_oe && area_byte_sram[ar] |-> !rd_wr_n) else $error("no we");
    oe_strobe_a: assert property (
        data_oe |-> !v_n) else $error("data driven outside access");
    rd_c: cover property (!read_strobe_n);
    wr_c: cover property (data_oe && !upper_write_strobe_n);
    ack_c: cover property (ack);
endmodule // bssp_port_props
bind bssp_port bssp_port_props u_bssp_port_props (
    .mclk, .rst_b, .req, .ack, .area_byte_sram, .area_wide, .addr_out,
    .address_valid_strobe_n, .area_select_n, .read_strobe_n, .rd_wr_n,
    .upper_write_strobe_n, .data_oe);

// ---- bssp_sram_model.sv ----
// byte-select sram sitting on one area select of the port
// assumes its select stays high through reset
module bssp_sram_model
    import bssp_pkg::*;
(
    // clock and mode
    input wire logic       mclk,
    input wire logic       slow,
    // sram pins
    input wire logic       cs_n,
    input wire logic       oe_n,
    input wire logic       we_n,
    input wire logic       ub_n,
    input wire logic       lb_n,
    input wire bssp_addr_t addr,
    input wire bssp_data_t wdata,
    output bssp_data_t     rdata,
    output logic           wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    bssp_data_t mem [8];
    bssp_data_t last_reg = 16'h5a5a;
    logic [3:0] cnt_reg = 4'h0;
    // released bus shows the inverse so a stale value never matches
    assign rdata = (!cs_n && !oe_n) ? mem[addr[3:1]] : ~last_reg;
    assign wait_n = !(slow && !cs_n && cnt_reg < 4'h3);
    always_ff @(posedge mclk) begin
        cnt_reg <= cs_n ? 4'h0 : cnt_reg + 4'h1;
        if (!cs_n && !oe_n) last_reg <= rdata;
        if (!cs_n && !we_n && !ub_n) mem[addr[3:1]][15:8] <= wdata[15:8];
        if (!cs_n && !we_n && !lb_n) mem[addr[3:1]][7:0] <= wdata[7:0];
    end
endmodule // bssp_sram_model

// ---- test_byte_select_sram_bus_port.sv ----
// self-checking bench for the byte-select sram bus port
// assumes sram model on area 1 (wide), area 3 narrow byte sram
module test_byte_select_sram_bus_port
    import bssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 0, rst_b = 0, req = 0, req_write = 0, slow = 0;
    logic       req_single_dma = 0, idle_en = 0, ack, avs_n, rd_n, rw_n;
    logic       uws_n, lws_n, wait_n, data_oe, clk_en = 1;
    logic [1:0] req_bytes = 0, idle_sel = 0;
    logic [7:0] sel_n;
    bssp_addr_t req_addr = 0, addr_out;
    bssp_data_t req_wdata = 0, rdata, data_in, data_out;
    int         n_fail = 0, tests_run = 0, lat;
    bssp_port u_bssp_port (.mclk, .clk_en, .rst_b,
        .idle_after_single_write_en(idle_en), .idle_count_sel_hi(idle_sel[1]),
        .idle_count_sel_lo(idle_sel[0]), .area_byte_sram(8'h0a),
        .area_wide(8'h02), .req, .req_write, .req_single_dma, .req_bytes,
        .req_addr, .req_wdata, .ack, .rdata, .addr_out,
        .address_valid_strobe_n(avs_n), .area_select_n(sel_n),
        .read_strobe_n(rd_n), .rd_wr_n(rw_n), .upper_write_strobe_n(uws_n),
        .lower_write_strobe_n(lws_n), .wait_n, .data_in, .data_out, .data_oe);
    bssp_sram_model u_bssp_sram_model (.mclk, .slow, .cs_n(sel_n[1]),
        .oe_n(rd_n), .we_n(rw_n), .ub_n(uws_n), .lb_n(lws_n),
        .addr(addr_out), .wdata(data_out), .rdata(data_in), .wait_n);
    initial begin
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(logic [23:0] got, logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // request held until ack; lat counts edges from drive to ack seen
    task automatic acc(logic w, logic s, logic [1:0] b, bssp_addr_t a,
                       bssp_data_t d);
        @(posedge mclk);
        req <= 1'b1;
        req_write <= w;
        req_single_dma <= s;
        req_bytes <= b;
        req_addr <= a;
        req_wdata <= d;
        lat = 0;
        do begin
            @(posedge mclk);
            lat++;
        end while (ack !== 1'b1 && lat < 60);
        req <= 1'b0;
        if (lat >= 60) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic t_bytes();
        acc(1, 0, 2'h3, 24'h200002, 16'h1234);
        chk(lat, 5);
        acc(1, 0, 2'h1, 24'h200002, 16'hffcd);
        acc(1, 0, 2'h2, 24'h200002, 16'hab77);
        acc(1, 0, 2'h3, 24'h200004, 16'h5555);
        acc(0, 0, 2'h3, 24'h200002, 16'h0000);
        chk(rdata, 16'habcd);
    endtask
    task automatic t_wait();
        slow <= 1'b1;
        acc(0, 0, 2'h3, 24'h200004, 16'h0000);
        chk(lat, 8);
        chk(rdata, 16'h5555);
        slow <= 1'b0;
    endtask
    // clk_en low mid-access must stretch it, not lose it
    task automatic t_freeze();
        fork
            acc(0, 0, 2'h3, 24'h200004, 16'h0000);
            begin
                repeat (3) @(posedge mclk);
                clk_en <= 1'b0;
                repeat (2) @(posedge mclk);
                chk(avs_n, 1'b0);
                clk_en <= 1'b1;
            end
        join
        chk(lat, 7);
        chk(rdata, 16'h5555);
    endtask
    task automatic t_gap();
        idle_en <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            idle_sel <= g[1:0];
            acc(1, 1, 2'h3, 24'h400000, 16'h0f0f);
            acc(1, 0, 2'h3, 24'h200006, 16'h3c3c);
            chk(lat, 5 + g);
        end
        idle_en <= 1'b0;
        acc(1, 1, 2'h3, 24'h400000, 16'h0f0f);
        acc(0, 0, 2'h3, 24'h600000, 16'h0000);
        chk(lat, 5);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        chk({ack, data_oe, avs_n, rd_n, uws_n, lws_n, sel_n}, 14'h0fff);
        rst_b <= 1'b1;
        t_bytes();
        t_wait();
        t_freeze();
        t_gap();
        summarize();
    end
endmodule // test_byte_select_sram_bus_port
